// file: hw/aotr_regs.vh
// aotr_regs.vh: register offsets, field layouts and reset values of the trim bank
// assumes: included by the trim bank module by bare name
`ifndef AOTR_REGS_VH
`define AOTR_REGS_VH

// register indices, byte address is four times the index
`define AOTR_IDX_CORE2_SECOND_INPUT_OFFSET 12'h336
`define AOTR_IDX_CORE3_THIRD_INPUT_OFFSET  12'h338
`define AOTR_IDX_CORE3_FOURTH_INPUT_OFFSET 12'h33A
`define AOTR_IDX_CORE4_OFFSET_VALUE        12'h33C
`define AOTR_IDX_CORE5_OFFSET_VALUE        12'h33E
`define AOTR_IDX_CORE0_GAIN_VALUE          12'h360
`define AOTR_IDX_CORE1_GAIN_VALUE          12'h361
`define AOTR_IDX_CORE2_FIRST_INPUT_GAIN    12'h362
// control and status registers
`define AOTR_IDX_INPUT_SELECT              12'h370
`define AOTR_IDX_FUSE_CTRL                 12'h371
`define AOTR_IDX_STATUS                    12'h372

// field layout
`define AOTR_OFS_MSB   11
`define AOTR_OFS_W     12
`define AOTR_GAIN_MSB  4
`define AOTR_GAIN_W    5

// reset values
`define AOTR_OFS_RST   12'h000
`define AOTR_GAIN_RST  5'h00

// axi responses
`define AOTR_RESP_OKAY   2'h0
`define AOTR_RESP_SLVERR 2'h2

`endif

// file: hw/aotr_trim_regs.v
// aotr_trim_regs.v: offset and fine-gain trim register bank on an AXI4-Lite slave
// assumes: one clock, synchronous active-high reset, fuse values stable while loading
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "aotr_regs.vh"

module aotr_trim_regs #(
    parameter OFS_W  = `AOTR_OFS_W,
    parameter GAIN_W = `AOTR_GAIN_W
) (
    // clock and reset
    input  wire                 core_clk_i,
    input  wire                 rst_i,
    // axi4-lite write address
    input  wire [13:0]          s_axi_awaddr_i,
    input  wire                 s_axi_awvalid_i,
    output wire                 s_axi_awready_o,
    // axi4-lite write data
    input  wire [31:0]          s_axi_wdata_i,
    input  wire [3:0]           s_axi_wstrb_i,
    input  wire                 s_axi_wvalid_i,
    output wire                 s_axi_wready_o,
    // axi4-lite write response
    output reg  [1:0]           s_axi_bresp_o,
    output reg                  s_axi_bvalid_o,
    input  wire                 s_axi_bready_i,
    // axi4-lite read
    input  wire [13:0]          s_axi_araddr_i,
    input  wire                 s_axi_arvalid_i,
    output wire                 s_axi_arready_o,
    output reg  [31:0]          s_axi_rdata_o,
    output reg  [1:0]           s_axi_rresp_o,
    output reg                  s_axi_rvalid_o,
    input  wire                 s_axi_rready_i,
    // fuse defaults
    input  wire [OFS_W-1:0]     fuse_core2_second_input_offset_i,
    input  wire [OFS_W-1:0]     fuse_core3_third_input_offset_i,
    input  wire [OFS_W-1:0]     fuse_core3_fourth_input_offset_i,
    input  wire [OFS_W-1:0]     fuse_core4_offset_value_i,
    input  wire [OFS_W-1:0]     fuse_core5_offset_value_i,
    input  wire [GAIN_W-1:0]    fuse_core0_gain_value_i,
    input  wire [GAIN_W-1:0]    fuse_core1_gain_value_i,
    input  wire [GAIN_W-1:0]    fuse_core2_first_input_gain_i,
    // applied trims toward the cores
    output reg  [OFS_W-1:0]     core2_offset_o,
    output reg  [OFS_W-1:0]     core3_offset_o,
    output reg  [OFS_W-1:0]     core4_offset_o,
    output reg  [OFS_W-1:0]     core5_offset_o,
    output reg  [GAIN_W-1:0]    core0_gain_o,
    output reg  [GAIN_W-1:0]    core1_gain_o,
    output reg  [GAIN_W-1:0]    core2_gain_o,
    output wire                 core2_offset_valid_o,
    // external core 2 second-input gain, kept outside this bank
    input  wire [GAIN_W-1:0]    core2_second_input_gain_i
);

    // register selectors
    localparam [3:0] SEL_O2B  = 4'h0;
    localparam [3:0] SEL_O3C  = 4'h1;
    localparam [3:0] SEL_O3D  = 4'h2;
    localparam [3:0] SEL_O4   = 4'h3;
    localparam [3:0] SEL_O5   = 4'h4;
    localparam [3:0] SEL_G0   = 4'h5;
    localparam [3:0] SEL_G1   = 4'h6;
    localparam [3:0] SEL_G2A  = 4'h7;
    localparam [3:0] SEL_INS  = 4'h8;
    localparam [3:0] SEL_FUSE = 4'h9;
    localparam [3:0] SEL_STAT = 4'hA;
    localparam [3:0] SEL_NONE = 4'hF;

    // byte address to register selector, shared by both paths
    function [3:0] aotr_decode;
        input [13:0] addr;
        begin
            if (addr[1:0] != 2'h0) begin
                aotr_decode = SEL_NONE;
            end else begin
                case (addr[13:2])
                    `AOTR_IDX_CORE2_SECOND_INPUT_OFFSET: aotr_decode = SEL_O2B;
                    `AOTR_IDX_CORE3_THIRD_INPUT_OFFSET:  aotr_decode = SEL_O3C;
                    `AOTR_IDX_CORE3_FOURTH_INPUT_OFFSET: aotr_decode = SEL_O3D;
                    `AOTR_IDX_CORE4_OFFSET_VALUE:        aotr_decode = SEL_O4;
                    `AOTR_IDX_CORE5_OFFSET_VALUE:        aotr_decode = SEL_O5;
                    `AOTR_IDX_CORE0_GAIN_VALUE:          aotr_decode = SEL_G0;
                    `AOTR_IDX_CORE1_GAIN_VALUE:          aotr_decode = SEL_G1;
                    `AOTR_IDX_CORE2_FIRST_INPUT_GAIN:    aotr_decode = SEL_G2A;
                    `AOTR_IDX_INPUT_SELECT:              aotr_decode = SEL_INS;
                    `AOTR_IDX_FUSE_CTRL:                 aotr_decode = SEL_FUSE;
                    `AOTR_IDX_STATUS:                    aotr_decode = SEL_STAT;
                    default:                             aotr_decode = SEL_NONE;
                endcase
            end
        end
    endfunction

    // stored trims
    reg [OFS_W-1:0]  core2_second_input_offset_reg;
    reg [OFS_W-1:0]  core3_third_input_offset_reg;
    reg [OFS_W-1:0]  core3_fourth_input_offset_reg;
    reg [OFS_W-1:0]  core4_offset_value_reg;
    reg [OFS_W-1:0]  core5_offset_value_reg;
    reg [GAIN_W-1:0] core0_gain_value_reg;
    reg [GAIN_W-1:0] core1_gain_value_reg;
    reg [GAIN_W-1:0] core2_first_input_gain_reg;
    // core 2 input select (0 first, 1 second), core 3 select (0 third, 1 fourth)
    reg              core2_input_reg;
    reg              core3_input_reg;
    reg              fuse_loaded_reg;
    reg              fuse_load_reg;

    // write channel holding
    reg              aw_held_reg;
    reg              w_held_reg;
    reg [13:0]       awaddr_reg;
    reg [31:0]       wdata_reg;
    reg [3:0]        wstrb_reg;

    wire             wr_fire;
    wire [3:0]       wr_sel;
    wire [31:0]      wr_data;
    wire [3:0]       wr_strb;
    wire             ofs_lo_en;
    wire             ofs_hi_en;

    // each channel accepted once per write, both before response
    assign s_axi_awready_o = !aw_held_reg && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_held_reg && !s_axi_bvalid_o;

    // write happens when both address and data are in hand
    assign wr_fire = (aw_held_reg || (s_axi_awvalid_i && s_axi_awready_o)) &&
                     (w_held_reg || (s_axi_wvalid_i && s_axi_wready_o));
    assign wr_sel  = aotr_decode(aw_held_reg ? awaddr_reg : s_axi_awaddr_i);
    assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata_i;
    assign wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb_i;
    assign ofs_lo_en = wr_fire && wr_strb[0];
    assign ofs_hi_en = wr_fire && wr_strb[1];

    // write channel capture and response
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            aw_held_reg    <= 1'b0;
            w_held_reg     <= 1'b0;
            awaddr_reg     <= 14'h0000;
            wdata_reg      <= 32'h00000000;
            wstrb_reg      <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `AOTR_RESP_OKAY;
        end else if (wr_fire) begin
            aw_held_reg    <= 1'b0;
            w_held_reg     <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= (wr_sel == SEL_NONE || wr_sel == SEL_STAT) ?
                              `AOTR_RESP_SLVERR : `AOTR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata_i;
                wstrb_reg  <= s_axi_wstrb_i;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // trim storage: fuse load, then software writes; reserved bits never stored
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            core2_second_input_offset_reg <= `AOTR_OFS_RST;
            core3_third_input_offset_reg  <= `AOTR_OFS_RST;
            core3_fourth_input_offset_reg <= `AOTR_OFS_RST;
            core4_offset_value_reg        <= `AOTR_OFS_RST;
            core5_offset_value_reg        <= `AOTR_OFS_RST;
            core0_gain_value_reg          <= `AOTR_GAIN_RST;
            core1_gain_value_reg          <= `AOTR_GAIN_RST;
            core2_first_input_gain_reg    <= `AOTR_GAIN_RST;
            core2_input_reg               <= 1'b0;
            core3_input_reg               <= 1'b0;
            fuse_load_reg                 <= 1'b1;
            fuse_loaded_reg               <= 1'b0;
        end else if (fuse_load_reg) begin
            core2_second_input_offset_reg <= fuse_core2_second_input_offset_i;
            core3_third_input_offset_reg  <= fuse_core3_third_input_offset_i;
            core3_fourth_input_offset_reg <= fuse_core3_fourth_input_offset_i;
            core4_offset_value_reg        <= fuse_core4_offset_value_i;
            core5_offset_value_reg        <= fuse_core5_offset_value_i;
            core0_gain_value_reg          <= fuse_core0_gain_value_i;
            core1_gain_value_reg          <= fuse_core1_gain_value_i;
            core2_first_input_gain_reg    <= fuse_core2_first_input_gain_i;
            fuse_load_reg                 <= 1'b0;
            fuse_loaded_reg               <= 1'b1;
        end else begin
            // byte lanes 0 and 1 carry the offset field, lane 0 the gain field
            case (wr_sel)
                SEL_O2B: begin
                    if (ofs_lo_en) core2_second_input_offset_reg[7:0]  <= wr_data[7:0];
                    if (ofs_hi_en) core2_second_input_offset_reg[11:8] <= wr_data[11:8];
                end
                SEL_O3C: begin
                    if (ofs_lo_en) core3_third_input_offset_reg[7:0]  <= wr_data[7:0];
                    if (ofs_hi_en) core3_third_input_offset_reg[11:8] <= wr_data[11:8];
                end
                SEL_O3D: begin
                    if (ofs_lo_en) core3_fourth_input_offset_reg[7:0]  <= wr_data[7:0];
                    if (ofs_hi_en) core3_fourth_input_offset_reg[11:8] <= wr_data[11:8];
                end
                SEL_O4: begin
                    if (ofs_lo_en) core4_offset_value_reg[7:0]  <= wr_data[7:0];
                    if (ofs_hi_en) core4_offset_value_reg[11:8] <= wr_data[11:8];
                end
                SEL_O5: begin
                    if (ofs_lo_en) core5_offset_value_reg[7:0]  <= wr_data[7:0];
                    if (ofs_hi_en) core5_offset_value_reg[11:8] <= wr_data[11:8];
                end
                SEL_G0: begin
                    if (ofs_lo_en) core0_gain_value_reg <= wr_data[`AOTR_GAIN_MSB:0];
                end
                SEL_G1: begin
                    if (ofs_lo_en) core1_gain_value_reg <= wr_data[`AOTR_GAIN_MSB:0];
                end
                SEL_G2A: begin
                    if (ofs_lo_en) core2_first_input_gain_reg <= wr_data[`AOTR_GAIN_MSB:0];
                end
                SEL_INS: begin
                    if (ofs_lo_en) begin
                        core2_input_reg <= wr_data[0];
                        core3_input_reg <= wr_data[1];
                    end
                end
                SEL_FUSE: begin
                    if (ofs_lo_en && wr_data[0]) fuse_load_reg <= 1'b1; // reload request
                end
                default: begin
                end
            endcase
        end
    end

    // core 2 offset only valid while its second input is sampled
    assign core2_offset_valid_o = core2_input_reg;

    // applied trims, unsigned fields passed straight through
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            core2_offset_o <= `AOTR_OFS_RST;
            core3_offset_o <= `AOTR_OFS_RST;
            core4_offset_o <= `AOTR_OFS_RST;
            core5_offset_o <= `AOTR_OFS_RST;
            core0_gain_o   <= `AOTR_GAIN_RST;
            core1_gain_o   <= `AOTR_GAIN_RST;
            core2_gain_o   <= `AOTR_GAIN_RST;
        end else begin
            core2_offset_o <= core2_input_reg ? core2_second_input_offset_reg
                                              : `AOTR_OFS_RST;
            core3_offset_o <= core3_input_reg ? core3_fourth_input_offset_reg
                                              : core3_third_input_offset_reg;
            core4_offset_o <= core4_offset_value_reg;
            core5_offset_o <= core5_offset_value_reg;
            core0_gain_o   <= core0_gain_value_reg;
            core1_gain_o   <= core1_gain_value_reg;
            core2_gain_o   <= core2_input_reg ? core2_second_input_gain_i
                                              : core2_first_input_gain_reg;
        end
    end

    // read data mux, reserved bits read zero
    reg  [31:0] rd_mux;
    wire [3:0]  rd_sel;
    assign rd_sel = aotr_decode(s_axi_araddr_i);

    always @* begin
        rd_mux = 32'h00000000;
        case (rd_sel)
            SEL_O2B:  rd_mux = {20'h00000, core2_second_input_offset_reg};
            SEL_O3C:  rd_mux = {20'h00000, core3_third_input_offset_reg};
            SEL_O3D:  rd_mux = {20'h00000, core3_fourth_input_offset_reg};
            SEL_O4:   rd_mux = {20'h00000, core4_offset_value_reg};
            SEL_O5:   rd_mux = {20'h00000, core5_offset_value_reg};
            SEL_G0:   rd_mux = {27'h0, core0_gain_value_reg};
            SEL_G1:   rd_mux = {27'h0, core1_gain_value_reg};
            SEL_G2A:  rd_mux = {27'h0, core2_first_input_gain_reg};
            SEL_INS:  rd_mux = {30'h0, core3_input_reg, core2_input_reg};
            SEL_FUSE: rd_mux = {31'h0, fuse_load_reg};
            SEL_STAT: rd_mux = {31'h0, fuse_loaded_reg};
            default:  rd_mux = 32'h00000000;
        endcase
    end

    // read channel: one outstanding read
    assign s_axi_arready_o = !s_axi_rvalid_o;

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h00000000;
            s_axi_rresp_o  <= `AOTR_RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_mux;
            s_axi_rresp_o  <= (rd_sel == SEL_NONE) ? `AOTR_RESP_SLVERR : `AOTR_RESP_OKAY;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

endmodule // aotr_trim_regs

// file: verif/aotr_trim_regs_checker.sv
// aotr_trim_regs_checker.sv: port checks of the trim register bank
// assumes: bound to aotr_trim_regs, byte address four times the index, full strobes
`timescale 1ns/1ns
module aotr_trim_regs_checker (
    // clock and reset
    input wire        core_clk_i,
    input wire        rst_i,
    // register bus
    input wire [13:0] s_axi_awaddr_i,
    input wire        s_axi_awvalid_i,
    input wire        s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire        s_axi_wvalid_i,
    input wire        s_axi_wready_o,
    input wire [1:0]  s_axi_bresp_o,
    input wire [13:0] s_axi_araddr_i,
    input wire        s_axi_arvalid_i,
    input wire        s_axi_arready_o,
    input wire [31:0] s_axi_rdata_o,
    // trims and select
    input wire [11:0] core2_offset_o,
    input wire [11:0] core4_offset_o,
    input wire [4:0]  core2_gain_o,
    input wire        core2_offset_valid_o,
    input wire [4:0]  core2_second_input_gain_i
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // both write channels taken at one edge, read request taken
    wire        wr = s_axi_awvalid_i & s_axi_awready_o & s_axi_wvalid_i & s_axi_wready_o;
    wire        rd = s_axi_arvalid_i & s_axi_arready_o;
    wire [13:0] wa = s_axi_awaddr_i;
    wire [13:0] ra = s_axi_araddr_i;
    wire [11:0] wo = s_axi_wdata_i[11:0];
    a_first_input_zero: assert property (
        !core2_offset_valid_o |=> core2_offset_o == 12'h000) else $error("core2 offset not zero");
    a_second_in_gain: assert property (
        core2_offset_valid_o |=> core2_gain_o == $past(core2_second_input_gain_i))
        else $error("core2 gain not external");
    a_unmapped_error: assert property (
        wr && (wa[1:0] != 2'h0 || wa < 14'hCD8) |=> s_axi_bresp_o == 2'h2)
        else $error("bad address not refused");
    a_offset_okay: assert property (
        wr && wa inside {14'hCD8, 14'hCE0, 14'hCE8, 14'hCF0, 14'hCF8} |=> s_axi_bresp_o == 2'h0)
        else $error("offset write refused");
    a_gain_okay: assert property (
        wr && wa inside {14'hD80, 14'hD84, 14'hD88} |=> s_axi_bresp_o == 2'h0)
        else $error("gain write refused");
    a_offset_rsvd_zero: assert property (
        rd && ra inside {14'hCD8, 14'hCE0, 14'hCE8, 14'hCF0, 14'hCF8}
        |=> s_axi_rdata_o[31:12] == 20'h0) else $error("offset reserved bits set");
    a_gain_rsvd_zero: assert property (
        rd && ra inside {14'hD80, 14'hD84, 14'hD88} |=> s_axi_rdata_o[31:5] == 27'h0)
        else $error("gain reserved bits set");
    a_offset_applied: assert property (
        wr && !$past(rst_i) && wa == 14'hCF0 |=> ##1 core4_offset_o == $past(wo, 2))
        else $error("core4 offset not applied");
endmodule // aotr_trim_regs_checker

// attach to every trim bank instance
bind aotr_trim_regs aotr_trim_regs_checker i_chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
    .core2_offset_o(core2_offset_o), .core4_offset_o(core4_offset_o),
    .core2_gain_o(core2_gain_o), .core2_offset_valid_o(core2_offset_valid_o),
    .core2_second_input_gain_i(core2_second_input_gain_i)
);

// file: verif/aotr_trim_regs_tb.sv
// aotr_trim_regs_tb.sv: self-checking bench of the trim register bank
// assumes: hw/ on the include path, checker bound in its own file
`timescale 1ns/1ns
`include "aotr_regs.vh"
module aotr_trim_regs_tb;
    // stimulus
    logic        clk = 0;
    logic        rst = 1;
    logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [13:0] awa = 14'h0000, ara = 14'h0000;
    logic [31:0] wd = 32'h0;
    logic [4:0]  ext = 5'h1A;
    logic [11:0] fo [5] = '{12'h2B1, 12'h3C2, 12'h3D3, 12'h4A4, 12'h5A5};
    logic [4:0]  fg [3] = '{5'h10, 5'h11, 5'h12};
    logic [11:0] vo [5] = '{12'hFFF, 12'h000, 12'hA5C, 12'h5A3, 12'h801};
    logic [4:0]  vg [3] = '{5'h1F, 5'h00, 5'h0B};
    // design answers
    wire         awr, wr, bv, arr, rv, c2v;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [11:0]  c2o, c3o, c4o, c5o;
    wire [4:0]   g0o, g1o, g2o;
    int          fails = 0;
    int          compares = 0;
    int          i;
    aotr_trim_regs i_dut (
        .core_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
        .fuse_core2_second_input_offset_i(fo[0]), .fuse_core3_third_input_offset_i(fo[1]),
        .fuse_core3_fourth_input_offset_i(fo[2]), .fuse_core4_offset_value_i(fo[3]),
        .fuse_core5_offset_value_i(fo[4]), .fuse_core0_gain_value_i(fg[0]),
        .fuse_core1_gain_value_i(fg[1]), .fuse_core2_first_input_gain_i(fg[2]),
        .core2_offset_o(c2o), .core3_offset_o(c3o), .core4_offset_o(c4o), .core5_offset_o(c5o),
        .core0_gain_o(g0o), .core1_gain_o(g1o), .core2_gain_o(g2o),
        .core2_offset_valid_o(c2v), .core2_second_input_gain_i(ext)
    );
    // clock and reset
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
    end
    // byte addresses of offset k and gain k
    function automatic [13:0] oa(input int k);
        oa = {`AOTR_IDX_CORE2_SECOND_INPUT_OFFSET, 2'h0} + 14'(8 * k);
    endfunction
    function automatic [13:0] ga(input int k);
        ga = {`AOTR_IDX_CORE0_GAIN_VALUE, 2'h0} + 14'(4 * k);
    endfunction
    // compare and count
    task automatic chk(input [31:0] got, input [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // counts, verdict, end of run
    task automatic finish_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // a bus wait that used its whole bound ends the run
    task automatic lim(input int n);
        if (n >= 20) begin
            fails++;
            $display("unexpected at %0t: no bus answer", $time);
            finish_test();
        end
    endtask
    // write with both channels offered together, response checked
    task automatic wchk(input [13:0] a, input [31:0] d, input [1:0] er, input string m);
        int n;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        br <= 1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
            if (bv) break;
        end
        br <= 0;
        lim(n);
        chk(bresp, er, m);
    endtask
    // read, response checked, data checked only when OKAY is expected
    task automatic rchk(input [13:0] a, input [31:0] e, input [1:0] er, input string m);
        int n;
        @(posedge clk);
        ara <= a;
        arv <= 1;
        rr <= 1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (arr) arv <= 0;
            if (rv) break;
        end
        rr <= 0;
        lim(n);
        chk(rresp, er, m);
        if (er == 2'h0) chk(rdata, e, m);
    endtask
    // applied trims toward the cores
    task automatic outs(input [11:0] o2, o3, o4, o5, input [4:0] h0, h1, h2);
        #1;
        chk(c2o, o2, "core2 offset");
        chk(c3o, o3, "core3 offset");
        chk(c4o, o4, "core4 offset");
        chk(c5o, o5, "core5 offset");
        chk(g0o, h0, "core0 gain");
        chk(g1o, h1, "core1 gain");
        chk(g2o, h2, "core2 gain");
    endtask
    // all trims read back against the fuse values
    task automatic fuse_check();
        for (int k = 0; k < 5; k++) rchk(oa(k), {20'h0, fo[k]}, 2'h0, "fuse ofs");
        for (int k = 0; k < 3; k++) rchk(ga(k), {27'h0, fg[k]}, 2'h0, "fuse gain");
    endtask
    // test sequence
    initial begin
        @(posedge clk);
        outs(12'h000, 12'h000, 12'h000, 12'h000, 5'h00, 5'h00, 5'h00);
        repeat (5) @(posedge clk);
        fuse_check();
        outs(12'h000, fo[1], fo[3], fo[4], fg[0], fg[1], fg[2]);
        $display("test fuse defaults done");
        for (i = 0; i < 5; i++) wchk(oa(i), {20'hFFFFF, vo[i]}, 2'h0, "ofs wr");
        for (i = 0; i < 5; i++) rchk(oa(i), {20'h0, vo[i]}, 2'h0, "ofs rd");
        for (i = 0; i < 3; i++) wchk(ga(i), {27'h7FFFFFF, vg[i]}, 2'h0, "gain wr");
        for (i = 0; i < 3; i++) rchk(ga(i), {27'h0, vg[i]}, 2'h0, "gain rd");
        outs(12'h000, vo[1], vo[3], vo[4], vg[0], vg[1], vg[2]);
        $display("test write and read back done");
        wchk({`AOTR_IDX_INPUT_SELECT, 2'h0}, 32'h3, 2'h0, "select");
        outs(vo[0], vo[2], vo[3], vo[4], vg[0], vg[1], ext);
        $display("test input select done");
        wchk(14'h0000, 32'h5, 2'h2, "unmapped wr");
        wchk(oa(3) + 14'h0002, 32'h1, 2'h2, "unaligned wr");
        rchk(14'h0000, 32'h0, 2'h2, "unmapped rd");
        rchk(oa(3), {20'h0, vo[3]}, 2'h0, "untouched");
        wchk({`AOTR_IDX_STATUS, 2'h0}, 32'h0, 2'h2, "status wr");
        rchk({`AOTR_IDX_STATUS, 2'h0}, 32'h1, 2'h0, "status rd");
        $display("test refused access done");
        @(posedge clk);
        for (i = 0; i < 5; i++) fo[i] <= ~fo[i];
        for (i = 0; i < 3; i++) fg[i] <= ~fg[i];
        ext <= 5'h07;
        wchk({`AOTR_IDX_FUSE_CTRL, 2'h0}, 32'h1, 2'h0, "reload");
        fuse_check();
        outs(fo[0], fo[2], fo[3], fo[4], fg[0], fg[1], 5'h07);
        $display("test fuse reload done");
        finish_test();
    end
endmodule // aotr_trim_regs_tb
